// file: core/microstep_phase_current_table.sv
// Purpose: microstep phase-current lookup with a loadable profile table
// Assumes: load writes and step requests are synchronous one-cycle strobes
// Notes: current outputs are 6-bit trip codes, 63 meaning peak current
//
// Overview of operation
// [R1] sixteen 6-bit trip threshold entries held
// [R2] value 63 is peak, v is v/63
// [R3] host keeps positive half mirror symmetric
// [R4] host keeps negative half mirror symmetric
// [R5] zero forced at A 0/32, B 16/48
// [R6] entry n-1 gives phase A angle n
// [R7] sixteen writes in entry order, then spread
// [R8] direction bits decoded from the angle
// [R9] coarse step indices mapped onto 1/16 grid
// [R10] phase B is phase A shifted sixteen
// [R11] top entry only at peak angles
// [R12] angle counter wraps both ways
// [R13] table used only after sixteenth write
`timescale 1ns/100ps
`include "microstep_defs.svh"
module microstep_phase_current_table
    import microstep_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_load_valid,
    input wire logic [`MS_ENTRY_W-1:0] i_load_data,
    input wire logic [2:0] i_resolution,
    input wire logic i_step,
    input wire logic i_reverse,
    input wire logic i_index_load,
    input wire logic [5:0] i_step_index,
    output logic [`MS_ENTRY_W-1:0] o_current_a,
    output logic [`MS_ENTRY_W-1:0] o_current_b,
    output logic o_dir_a,
    output logic o_dir_b,
    output logic [`MS_ANGLE_W-1:0] o_angle,
    output logic o_table_loaded
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [`MS_ENTRY_W-1:0] shadow_q [`MS_ENTRIES];
    logic [`MS_ENTRY_W-1:0] active_q [`MS_ENTRIES];
    logic [`MS_TABLE_W-1:0] active_flat;
    logic [3:0] load_count_q;
    logic loaded_q;
    logic commit;
    angle_t angle_q;
    angle_t angle_d;
    angle_t angle_b;
    angle_t step_size;
    angle_t index_angle;
    resolution_t res;
    logic [`MS_ENTRY_W-1:0] mag_a;
    logic [`MS_ENTRY_W-1:0] mag_b;

    localparam logic [`MS_TABLE_W-1:0] TABLE_DEFAULT = `MS_TABLE_DEFAULT;

    assign res = resolution_t'(i_resolution);
    assign commit = i_load_valid && (load_count_q == `MS_LAST_ENTRY);

    // ------------------------------------------------------------
    // table load
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_count_q <= `MS_COUNT_RESET;
        end else if (i_load_valid) begin
            load_count_q <= load_count_q + 4'h1; // see [R7]
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loaded_q <= 1'b0;
        end else if (commit) begin
            loaded_q <= 1'b1;
        end
    end

    // the shadow keeps a half-written profile away from the bridges
    genvar e;
    generate
        for (e = 0; e < `MS_ENTRIES; e++) begin : g_entry
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    shadow_q[e] <= TABLE_DEFAULT[e*`MS_ENTRY_W +: `MS_ENTRY_W];
                end else if (i_load_valid && (load_count_q == 4'(e))) begin
                    shadow_q[e] <= i_load_data; // see [R1]
                end
            end
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    active_q[e] <= TABLE_DEFAULT[e*`MS_ENTRY_W +: `MS_ENTRY_W];
                end else if (commit) begin
                    if (e == `MS_ENTRIES - 1) begin
                        active_q[e] <= i_load_data; // see [R13]
                    end else begin
                        active_q[e] <= shadow_q[e]; // see [R13]
                    end
                end
            end
            assign active_flat[e*`MS_ENTRY_W +: `MS_ENTRY_W] = active_q[e];
        end
    endgenerate

    // ------------------------------------------------------------
    // angle counter
    // ------------------------------------------------------------
    always_comb begin
        unique case (res)
            RES_FULL: step_size = 6'h10;
            RES_HALF: step_size = 6'h08;
            RES_QUARTER: step_size = 6'h04;
            RES_EIGHTH: step_size = 6'h02;
            RES_SIXTEENTH: step_size = 6'h01;
            default: step_size = 6'h01;
        endcase
    end

    always_comb begin
        unique case (res)
            RES_FULL: index_angle = `MS_FULL_BASE + {i_step_index[1:0], 4'h0}; // see [R9]
            RES_HALF: index_angle = {i_step_index[2:0], 3'h0}; // see [R9]
            RES_QUARTER: index_angle = {i_step_index[3:0], 2'h0}; // see [R9]
            RES_EIGHTH: index_angle = {i_step_index[4:0], 1'b0}; // see [R9]
            RES_SIXTEENTH: index_angle = i_step_index;
            default: index_angle = i_step_index;
        endcase
    end

    // 6-bit arithmetic gives the wrap at both ends for free
    always_comb begin
        angle_d = angle_q;
        if (i_index_load) begin
            angle_d = index_angle;
        end else if (i_step && i_reverse) begin
            angle_d = angle_q - step_size; // see [R12]
        end else if (i_step) begin
            angle_d = angle_q + step_size; // see [R12]
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            angle_q <= `MS_ANGLE_RESET;
        end else begin
            angle_q <= angle_d;
        end
    end

    // ------------------------------------------------------------
    // lookup and outputs
    // ------------------------------------------------------------
    assign angle_b = angle_q + `MS_PHASE_B_OFFSET; // see [R10]

    phase_magnitude u_mag_a (
        .i_angle(angle_q),
        .i_table(active_flat),
        .o_magnitude(mag_a)
    );

    phase_magnitude u_mag_b (
        .i_angle(angle_b),
        .i_table(active_flat),
        .o_magnitude(mag_b)
    );

    // trip code passes straight to the comparator dac, 63 being peak
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_current_a <= 6'h00;
            o_current_b <= 6'h00;
        end else begin
            o_current_a <= mag_a; // see [R2]
            o_current_b <= mag_b; // see [R2]
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dir_a <= 1'b0;
            o_dir_b <= 1'b0;
        end else begin
            o_dir_a <= (angle_q >= `MS_DIR_A_FIRST); // see [R8]
            o_dir_b <= (angle_q >= `MS_DIR_B_FIRST) && (angle_q <= `MS_DIR_B_LAST); // see [R8]
        end
    end

    assign o_angle = angle_q;
    assign o_table_loaded = loaded_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_last_write;
        i_load_valid && (load_count_q == `MS_LAST_ENTRY);
    endsequence

    sequence s_partial_write;
        i_load_valid && (load_count_q != `MS_LAST_ENTRY);
    endsequence

    a_zero_phase_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R5]
        (angle_q == `MS_ZERO_A0 || angle_q == `MS_ZERO_A1) |=> (o_current_a == 6'h00))
        else $error("phase a not zero at its zero angles");

    a_zero_phase_b: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R5]
        (angle_q == `MS_ZERO_B0 || angle_q == `MS_ZERO_B1) |=> (o_current_b == 6'h00))
        else $error("phase b not zero at its zero angles");

    a_peak_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R11]
        (angle_q == 6'h10 || angle_q == 6'h30) && !commit
        |=> (o_current_a == active_q[15]) && (o_current_b == 6'h00))
        else $error("phase a peak does not use the top entry");

    a_first_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R6]
        (angle_q == 6'h1f) && !commit |=> (o_current_a == active_q[0]) &&
        (o_current_b == active_q[14]))
        else $error("angle 31 does not use entries 0 and 14");

    a_dir_decode: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R8]
        (angle_q == 6'h30) |=> o_dir_a && o_dir_b)
        else $error("direction bits wrong at angle 48");

    a_wrap_advance: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R12]
        (angle_q == 6'h3f) && i_step && !i_reverse && !i_index_load &&
        (res == RES_SIXTEENTH) |=> (angle_q == 6'h00))
        else $error("angle did not wrap from 63 to 0");

    a_wrap_retreat: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R12]
        (angle_q == 6'h00) && i_step && i_reverse && !i_index_load &&
        (res == RES_SIXTEENTH) |=> (angle_q == 6'h3f))
        else $error("angle did not wrap from 0 to 63");

    a_full_index: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R9]
        i_index_load && (res == RES_FULL) && (i_step_index[1:0] == 2'h1)
        |=> (angle_q == 6'h18))
        else $error("full step 1 did not map to angle 24");

    a_load_commit: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R7]
        s_last_write |=> (active_q[15] == $past(i_load_data)) &&
        (active_q[0] == $past(shadow_q[0])) && loaded_q && (load_count_q == 4'h0))
        else $error("sixteenth write did not commit the table");

    a_partial_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see [R13]
        s_partial_write |=> $stable(active_flat))
        else $error("partial load reached the active table");

endmodule // microstep_phase_current_table

// file: core/microstep_defs.svh
// Purpose: constants for the microstep phase-current table
// Assumes: 64 step angles per electrical cycle, sixteen 6-bit entries
// Notes: entry 0 sits in the low bits of the packed default table
`ifndef MICROSTEP_DEFS_SVH
`define MICROSTEP_DEFS_SVH

`define MS_ENTRY_W 6
`define MS_ENTRIES 16
`define MS_TABLE_W 96
`define MS_LAST_ENTRY 4'hf
`define MS_ANGLE_W 6
`define MS_ANGLE_RESET 6'h00
`define MS_PHASE_B_OFFSET 6'h10
`define MS_PEAK_VALUE 6'h3f
`define MS_ZERO_A0 6'h00
`define MS_ZERO_A1 6'h20
`define MS_ZERO_B0 6'h10
`define MS_ZERO_B1 6'h30
`define MS_DIR_A_FIRST 6'h21
`define MS_DIR_B_FIRST 6'h11
`define MS_DIR_B_LAST 6'h30
`define MS_FULL_BASE 6'h08
`define MS_COUNT_RESET 4'h0
// power-on profile, entry 15 first
`define MS_TABLE_DEFAULT {6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30, \
    6'h2c, 6'h28, 6'h23, 6'h1d, 6'h17, 6'h12, 6'h0b, 6'h05}

`endif

// file: core/microstep_pkg.sv
// Purpose: types shared by the microstep table files
// Assumes: nothing beyond the defs header
// Notes: resolution codes follow the order of the select input
package microstep_pkg;
    typedef enum logic [2:0] {
        RES_FULL,
        RES_HALF,
        RES_QUARTER,
        RES_EIGHTH,
        RES_SIXTEENTH
    } resolution_t;
    typedef logic [5:0] entry_t;
    typedef logic [5:0] angle_t;
endpackage

// file: core/phase_magnitude.sv
// Purpose: maps one phase angle onto a table entry magnitude
// Assumes: angle is already shifted into phase A coordinates
// Notes: purely combinational; the caller registers the result
`timescale 1ns/100ps
`include "microstep_defs.svh"
module phase_magnitude
    import microstep_pkg::*;
(
    input wire angle_t i_angle,
    input wire logic [`MS_TABLE_W-1:0] i_table,
    output logic [`MS_ENTRY_W-1:0] o_magnitude
);
    logic [4:0] half_pos;
    logic [3:0] index;

    assign half_pos = i_angle[4:0];

    // ------------------------------------------------------------
    // mirror fold onto entries
    // ------------------------------------------------------------
    always_comb begin
        if (half_pos <= 5'h10) begin
            index = 4'(half_pos - 5'h01); // see [R6]
        end else begin
            index = 4'(5'h1f - half_pos); // see [R11]
        end
        if (half_pos == 5'h00) begin
            o_magnitude = 6'h00; // see [R5]
        end else begin
            o_magnitude = i_table[index*`MS_ENTRY_W +: `MS_ENTRY_W];
        end
    end
endmodule // phase_magnitude

// file: testbench/load_host.sv
// Purpose: behavioural serial host that streams phase table entries
// Assumes: caller enters just after a rising clock edge
// Notes: idle data line shows the inverse of the last value, never a stale copy
`timescale 1ns/100ps
module load_host (
    input wire logic i_clk,
    output logic o_valid,
    output logic [5:0] o_data
);
    initial begin
        o_valid = 1'b0;
        o_data = 6'h2a;
    end
    // ------------------------------------------------------------
    // load sequence
    // ------------------------------------------------------------
    // only the first quadrant goes out; mirroring is implied by the format
    task automatic load(input logic [95:0] tbl, input int first, input int count,
        input int gap);
        for (int i = first; i < first + count; i++) begin
            o_valid <= 1'b1;
            o_data <= tbl[i*6 +: 6];
            @(posedge i_clk);
            if (gap != 0 || i == first + count - 1) begin
                o_valid <= 1'b0;
                o_data <= ~tbl[i*6 +: 6];
                repeat (gap) @(posedge i_clk);
            end
        end
        // one idle edge so the next caller never re-drives the strobe in this step
        @(posedge i_clk);
    endtask
endmodule // load_host

// file: testbench/tb_microstep_phase_current_table.sv
// Purpose: self-checking bench for the microstep phase-current table
// Assumes: step and index requests are one-cycle strobes, results two edges later
// Notes: expected values come from a bench-side lookup of the loaded profile
`timescale 1ns/100ps
`include "microstep_defs.svh"
module tb_microstep_phase_current_table
    import microstep_pkg::*;
;
    typedef struct packed {
        angle_t ang;
        entry_t a;
        entry_t b;
        logic da;
        logic db;
        logic ld;
    } exp_t;
    logic i_clk, i_reset_n, i_step, i_reverse, i_index_load;
    logic [2:0] i_resolution;
    logic [5:0] i_step_index;
    logic load_valid;
    logic [5:0] load_data;
    logic [5:0] o_current_a, o_current_b, o_angle;
    logic o_dir_a, o_dir_b, o_table_loaded;
    logic [95:0] tbl, nxt;
    angle_t ang;
    logic ld;
    exp_t q[$];
    exp_t e;
    logic [20:0] got;
    int n_mismatch, comparisons, seed;

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    microstep_phase_current_table uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_load_valid(load_valid), .i_load_data(load_data), .i_resolution(i_resolution),
        .i_step(i_step), .i_reverse(i_reverse), .i_index_load(i_index_load),
        .i_step_index(i_step_index), .o_current_a(o_current_a), .o_current_b(o_current_b),
        .o_dir_a(o_dir_a), .o_dir_b(o_dir_b), .o_angle(o_angle),
        .o_table_loaded(o_table_loaded));
    load_host host (.i_clk(i_clk), .o_valid(load_valid), .o_data(load_data));

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic entry_t mag(input angle_t a);
        int m;
        m = int'(a) % 32;
        if (m == 0) return 6'h00;
        if (m <= 16) return tbl[(m-1)*6 +: 6];
        return tbl[(31-m)*6 +: 6];
    endfunction

    task automatic push();
        exp_t x;
        x.ang = ang;
        x.a = mag(ang);
        x.b = mag(angle_t'(ang + 6'h10));
        x.da = (ang >= 6'h21);
        x.db = (ang >= 6'h11) && (ang <= 6'h30);
        x.ld = ld;
        q.push_back(x);
    endtask

    // one request, then note the expected outputs once they have settled
    task automatic op(input logic st, input logic il, input logic [2:0] res, input logic rev,
        input logic [5:0] idx);
        int sz;
        int mask;
        i_step <= st;
        i_index_load <= il;
        i_resolution <= res;
        i_reverse <= rev;
        i_step_index <= idx;
        @(posedge i_clk);
        i_step <= 1'b0;
        i_index_load <= 1'b0;
        @(posedge i_clk);
        sz = (res > 3'h3) ? 1 : (16 >> res);
        mask = (res > 3'h3) ? 63 : ((4 << res) - 1);
        if (il) ang = angle_t'(((res == 3'h0) ? 8 : 0) + sz * (int'(idx) & mask));
        else if (st) ang = rev ? angle_t'(ang - sz) : angle_t'(ang + sz);
        push();
    endtask

    // ------------------------------------------------------------
    // output monitor
    // ------------------------------------------------------------
    assign got = {o_angle, o_current_a, o_current_b, o_dir_a, o_dir_b, o_table_loaded};

    always @(negedge i_clk) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            comparisons++;
            if (got !== e) begin
                n_mismatch++;
                $display("mismatch at %0t: got %h %h %h %b%b%b expected %h", $time, o_angle,
                    o_current_a, o_current_b, o_dir_a, o_dir_b, o_table_loaded, e);
            end
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        seed = 73;
        tbl = `MS_TABLE_DEFAULT;
        ang = 6'h00;
        ld = 1'b0;
        i_reset_n = 1'b0;
        i_step = 1'b0;
        i_index_load = 1'b0;
        i_resolution = 3'h4;
        i_reverse = 1'b0;
        i_step_index = 6'h00;
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        push();
        for (int i = 0; i < 65; i++) op(1'b1, 1'b0, 3'h4, 1'b0, 6'h00);
        for (int i = 0; i < 2; i++) op(1'b1, 1'b0, 3'h4, 1'b1, 6'h00);
        for (int i = 0; i < 16; i++) nxt[i*6 +: 6] = 6'($random(seed));
        // a partial load must leave the old profile driving the outputs
        host.load(nxt, 0, 15, 0);
        // angle 5 reads entries 4 and 10, both rewritten in the shadow by now
        op(1'b0, 1'b1, 3'h4, 1'b0, 6'h05);
        host.load(nxt, 15, 1, 2);
        tbl = nxt;
        ld = 1'b1;
        for (int i = 0; i < 64; i++) op(1'b1, 1'b0, 3'h4, 1'b0, 6'h00);
        op(1'b0, 1'b1, 3'h0, 1'b0, 6'h01);
        // every resolution code: index, step, then index racing a step
        for (int r = 0; r < 8; r++) begin
            op(1'b0, 1'b1, 3'(r), 1'b0, 6'($random(seed)));
            op(1'b1, 1'b0, 3'(r), 1'(r), 6'h00);
            op(1'b1, 1'b1, 3'(r), 1'b0, 6'($random(seed)));
        end
        // slow reload of the power-on profile, then a random walk
        host.load(`MS_TABLE_DEFAULT, 0, 16, 1);
        tbl = `MS_TABLE_DEFAULT;
        for (int i = 0; i < 24; i++) op(1'b1, 1'b0, 3'h4, 1'($random(seed)), 6'h00);
        // the second falling edge lets the monitor drain the last note first
        repeat (2) @(negedge i_clk);
        close_out();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        close_out();
    end
endmodule // tb_microstep_phase_current_table
